/* File: sbsr_defines.svh */
// Constants for the status byte and service request block
// Function
// - Eight-bit enable mask ORs into master summary
// - Serial poll clears request flag only
// - Zero mask never raises service request
// - Mask query returns value unchanged
// - Status byte read has no side effect
// - Event summary bit clears via event register reads
// - Message flag follows output queue, clears
// - Serial poll puts request flag at bit6
// - Status byte bit layout 7..3, low zero
// - Bus trigger only with bus source
// - Self check returns 0/1, logs failures
// - Hold command stalls until operations done or device clear
// - Any protection query ORs four trip bits
// - Current trip query returns overcurrent bit
// - Voltage trip query returns overvoltage bit
// - Output enable alias, reset off, query 0/1
// - Compatibility commands only in standard language
// - Power-on clear flag clears or restores enable mask
// - Event status read clears it and summary
`ifndef SBSR_DEFINES_SVH
`define SBSR_DEFINES_SVH
`define SBSR_BIT_OPSUM 7
`define SBSR_BIT_MSUM 6
`define SBSR_BIT_EVSUM 5
`define SBSR_BIT_MSGW 4
`define SBSR_BIT_QSUM 3
`define SBSR_ZERO8 8'h00
`define SBSR_ZERO3 3'h0
`define SBSR_ESR_BITS 8
`endif

/* File: sbsr_pkg.sv */
// Types for the status byte and service request block
package sbsr_pkg;
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_SET_SRE,
		CMD_READ_SRE,
		CMD_READ_STB,
		CMD_SERIAL_POLL,
		CMD_CLEAR_STATUS,
		CMD_BUS_TRIGGER,
		CMD_SELF_CHECK,
		CMD_HOLD,
		CMD_READ_ESR,
		CMD_ANY_TRIP,
		CMD_CURR_TRIP,
		CMD_VOLT_TRIP,
		CMD_SET_OUTEN,
		CMD_READ_OUTEN
	} sbsr_cmd_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TEST,
		ST_HOLD
	} sbsr_state_t;
endpackage : sbsr_pkg

/* File: sbsr_sum_if.sv */
// Summary signals passed between the top and the summary unit
`timescale 1ns/1ps
interface sbsr_sum_if;
	logic [7:0] mask;
	logic [7:0] stb_raw;
	logic msum;
	logic rsvc;
	logic poll;
	logic clr;
	modport top (output mask, output stb_raw, output poll, output clr, input msum, input rsvc);
	modport unit (input mask, input stb_raw, input poll, input clr, output msum, output rsvc);
endinterface : sbsr_sum_if

/* File: sbsr_summary.sv */
// Master summary and request-for-service unit
`timescale 1ns/1ps
`include "sbsr_defines.svh"
module sbsr_summary (
	input wire logic CLK_I, // System clock
	input wire logic RESET_I, // Synchronous reset
	sbsr_sum_if.unit sum // Summary signals
);
	import sbsr_pkg::*;
	logic msum_d;
	logic msum_prev_q;
	logic rsvc_q;
	logic [7:0] fb_cut;

	// Enabled status bits ORed; bit 6 itself never feeds back
	always_comb begin
		fb_cut = `SBSR_ZERO8;
		fb_cut[`SBSR_BIT_MSUM] = 1'b1;
		msum_d = |(sum.mask & sum.stb_raw & ~fb_cut);
	end
	assign sum.msum = msum_d;
	assign sum.rsvc = rsvc_q;

	// Edge memory of the master summary
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			msum_prev_q <= 1'b0;
		end else begin
			msum_prev_q <= msum_d;
		end
	end

	// Rise sets the request; set wins over poll clear
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rsvc_q <= 1'b0;
		end else if (msum_d && !msum_prev_q) begin
			rsvc_q <= 1'b1;
		end else if (sum.poll || sum.clr || !msum_d) begin
			rsvc_q <= 1'b0;
		end
	end
endmodule : sbsr_summary

/* File: sbsr_top.sv */
// Status byte, service request and common command logic
`timescale 1ns/1ps
`include "sbsr_defines.svh"
module sbsr_top #(
	parameter int TEST_CYCLES = 16 // Length of the self check run
) (
	input wire logic CLK_I, // System clock
	input wire logic RESET_I, // Power-on reset, sync
	input wire logic CMD_VALID_I, // Command strobe
	input wire sbsr_pkg::sbsr_cmd_t CMD_I, // Command code
	input wire logic [7:0] CMD_DATA_I, // Command argument
	output logic CMD_READY_O, // Ready for a command
	output logic [7:0] RSP_DATA_O, // Response value
	output logic RSP_VALID_O, // Response strobe
	input wire logic POWER_ON_CLEAR_I, // Power-on clear flag
	input wire logic [7:0] NV_SRE_I, // Saved enable mask
	input wire logic LANG_STD_I, // Standard language selected
	input wire logic TRIG_SRC_BUS_I, // Trigger source is bus
	input wire logic DEVICE_CLEAR_I, // Bus device clear
	input wire logic OPS_PENDING_I, // Operations pending
	input wire logic OP_SUM_I, // Operation summary
	input wire logic QST_SUM_I, // Questionable summary
	input wire logic RSP_PENDING_I, // Output queue not empty
	input wire logic [7:0] ESR_EVENT_I, // Event status set pulses
	input wire logic [7:0] ESE_MASK_I, // Event status enable
	input wire logic OVOLT_I, // Overvoltage trip bit
	input wire logic OC_I, // Overcurrent trip bit
	input wire logic OTEMP_I, // Overtemperature trip bit
	input wire logic INHIBIT_I, // Remote inhibit bit
	input wire logic TEST_FAIL_I, // Self check failure level
	output logic SRQ_O, // Service request line
	output logic TRIGGER_O, // Trigger pulse
	output logic OUTPUT_ON_O, // Output enabled
	output logic ERR_PUSH_O, // Error queue push
	output logic [7:0] STB_O // Status byte
);
	import sbsr_pkg::*;
	sbsr_sum_if sum ();
	sbsr_state_t state_q;
	logic [7:0] sre_q;
	logic [7:0] esr_q;
	logic msgw_q;
	logic outen_q;
	logic fail_q;
	logic [15:0] cnt_q;
	logic por_q;
	logic [7:0] rsp_q;
	logic rspv_q;
	logic trig_q;
	logic err_q;
	logic [7:0] stb;
	logic evsum;
	logic take;

	sbsr_summary u_sum (
		.CLK_I(CLK_I),
		.RESET_I(RESET_I),
		.sum(sum)
	);

	////////////////////////////////////////////////////////////////
	// Status byte assembly
	assign evsum = |(esr_q & ESE_MASK_I);
	always_comb begin
		stb = `SBSR_ZERO8;
		stb[`SBSR_BIT_OPSUM] = OP_SUM_I;
		stb[`SBSR_BIT_EVSUM] = evsum;
		stb[`SBSR_BIT_MSGW] = msgw_q;
		stb[`SBSR_BIT_QSUM] = QST_SUM_I;
		stb[2:0] = `SBSR_ZERO3;
	end
	assign sum.mask = sre_q;
	assign sum.stb_raw = stb;
	assign take = CMD_VALID_I && CMD_READY_O;
	assign sum.poll = take && (CMD_I == CMD_SERIAL_POLL);
	assign sum.clr = take && (CMD_I == CMD_CLEAR_STATUS);
	assign CMD_READY_O = (state_q == ST_IDLE);
	assign SRQ_O = sum.rsvc;
	assign RSP_DATA_O = rsp_q;
	assign RSP_VALID_O = rspv_q;
	assign TRIGGER_O = trig_q;
	assign OUTPUT_ON_O = outen_q;
	assign ERR_PUSH_O = err_q;

	////////////////////////////////////////////////////////////////
	// Status byte output register, reads change nothing
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			STB_O <= `SBSR_ZERO8;
		end else begin
			STB_O <= stb | {1'b0, sum.msum, 6'h00};
		end
	end

	// Power-on marker so the enable mask loads once after reset release
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			por_q <= 1'b1;
		end else begin
			por_q <= 1'b0;
		end
	end

	// Enable mask: strap, or zero with power-on clear, loaded at first edge after reset
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sre_q <= `SBSR_ZERO8;
		end else if (por_q) begin
			sre_q <= POWER_ON_CLEAR_I ? `SBSR_ZERO8 : NV_SRE_I;
		end else if (take && CMD_I == CMD_SET_SRE) begin
			sre_q <= CMD_DATA_I;
		end
	end

	// Event status latch; new events win over the read clear
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			esr_q <= `SBSR_ZERO8;
		end else if (take && (CMD_I == CMD_READ_ESR || CMD_I == CMD_CLEAR_STATUS)) begin
			esr_q <= ESR_EVENT_I;
		end else begin
			esr_q <= esr_q | ESR_EVENT_I;
		end
	end

	// Message flag tracks the queue, cleared by clear status
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			msgw_q <= 1'b0;
		end else if (sum.clr) begin
			msgw_q <= 1'b0;
		end else begin
			msgw_q <= RSP_PENDING_I;
		end
	end

	// Output enable alias; ignored outside standard language
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			outen_q <= 1'b0;
		end else if (take && CMD_I == CMD_SET_OUTEN && LANG_STD_I) begin
			outen_q <= CMD_DATA_I != `SBSR_ZERO8;
		end
	end

	// Bus trigger only when source is bus
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= take && CMD_I == CMD_BUS_TRIGGER && TRIG_SRC_BUS_I;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer for self check and hold; hold ends when operations finish or on device clear
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			fail_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 16'h0000;
					fail_q <= 1'b0;
					if (take && CMD_I == CMD_SELF_CHECK) begin
						state_q <= ST_TEST;
					end else if (take && CMD_I == CMD_HOLD && OPS_PENDING_I) begin
						state_q <= ST_HOLD;
					end
				end
				ST_TEST: begin
					cnt_q <= cnt_q + 16'h0001;
					fail_q <= fail_q | TEST_FAIL_I;
					if (cnt_q == 16'(TEST_CYCLES - 1)) begin
						state_q <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (!OPS_PENDING_I || DEVICE_CLEAR_I) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// One error push per failing test cycle
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			err_q <= 1'b0;
		end else begin
			err_q <= (state_q == ST_TEST) && TEST_FAIL_I;
		end
	end

	////////////////////////////////////////////////////////////////
	// Query answers, one cycle after the command is taken; the self check answer comes TEST_CYCLES + 1 cycles after it is taken
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rsp_q <= `SBSR_ZERO8;
			rspv_q <= 1'b0;
		end else begin
			rspv_q <= 1'b0;
			if (state_q == ST_TEST && cnt_q == 16'(TEST_CYCLES - 1)) begin
				rsp_q <= {7'h00, fail_q | TEST_FAIL_I};
				rspv_q <= 1'b1;
			end else if (take) begin
				rspv_q <= 1'b1;
				case (CMD_I)
					CMD_READ_SRE: rsp_q <= sre_q;
					CMD_READ_STB: rsp_q <= stb | {1'b0, sum.msum, 6'h00};
					CMD_SERIAL_POLL: rsp_q <= stb | {1'b0, sum.rsvc, 6'h00};
					CMD_READ_ESR: rsp_q <= esr_q;
					CMD_ANY_TRIP: begin
						rsp_q <= {7'h00, OVOLT_I | OC_I | OTEMP_I | INHIBIT_I};
						rspv_q <= LANG_STD_I;
					end
					CMD_CURR_TRIP: begin
						rsp_q <= {7'h00, OC_I};
						rspv_q <= LANG_STD_I;
					end
					CMD_VOLT_TRIP: begin
						rsp_q <= {7'h00, OVOLT_I};
						rspv_q <= LANG_STD_I;
					end
					CMD_READ_OUTEN: begin
						rsp_q <= {7'h00, outen_q};
						rspv_q <= LANG_STD_I;
					end
					default: rspv_q <= 1'b0;
				endcase
			end
		end
	end
endmodule : sbsr_top

/* File: sbsr_chk.sv */
// Port checker for the status byte block
`timescale 1ns/1ps
module sbsr_chk (
	input wire logic CLK_I, // Clock
	input wire logic RESET_I, // Reset
	input wire logic CMD_VALID_I, // Strobe
	input wire sbsr_pkg::sbsr_cmd_t CMD_I, // Command
	input wire logic CMD_READY_O, // Ready
	input wire logic [7:0] RSP_DATA_O, // Answer
	input wire logic RSP_VALID_O, // Answer strobe
	input wire logic LANG_STD_I, // Language
	input wire logic TRIG_SRC_BUS_I, // Bus source
	input wire logic OVOLT_I, // Overvoltage
	input wire logic OC_I, // Overcurrent
	input wire logic OTEMP_I, // Overtemp
	input wire logic INHIBIT_I, // Inhibit
	input wire logic SRQ_O, // Request
	input wire logic TRIGGER_O, // Trigger
	input wire logic [7:0] STB_O // Status byte
);
	import sbsr_pkg::*;
	logic tk;
	////////////////////////////////////////////////////////////
	// Command accepted at this edge
	assign tk = CMD_VALID_I && CMD_READY_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	AST_LOW_ZERO: assert property (STB_O[2:0] == 3'h0)
		else $error("status byte low bits set");
	AST_STB_READ: assert property (tk && CMD_I == CMD_READ_STB |=> RSP_VALID_O && RSP_DATA_O == $past(STB_O))
		else $error("status read differs from status byte");
	AST_POLL_DATA: assert property (tk && CMD_I == CMD_SERIAL_POLL |=> RSP_VALID_O &&
		RSP_DATA_O == {$past(STB_O[7]), $past(SRQ_O), $past(STB_O[5:0])}) else $error("poll byte wrong");
	AST_POLL_CLR: assert property (tk && CMD_I == CMD_SERIAL_POLL && STB_O[6] && $past(STB_O[6])
		|=> STB_O[6] && !SRQ_O) else $error("poll did not clear request only");
	AST_TRIG_FIRE: assert property (tk && CMD_I == CMD_BUS_TRIGGER && TRIG_SRC_BUS_I |=> TRIGGER_O)
		else $error("bus trigger lost");
	AST_TRIG_ONLY: assert property ($rose(TRIGGER_O) |-> $past(tk && CMD_I == CMD_BUS_TRIGGER && TRIG_SRC_BUS_I))
		else $error("trigger without bus command");
	AST_ANY_TRIP: assert property (tk && LANG_STD_I && CMD_I == CMD_ANY_TRIP |=> RSP_VALID_O &&
		RSP_DATA_O == {7'h00, $past(OVOLT_I | OC_I | OTEMP_I | INHIBIT_I)}) else $error("trip summary wrong");
	AST_COMPAT_OFF: assert property (tk && !LANG_STD_I && CMD_I == CMD_ANY_TRIP |=> !RSP_VALID_O)
		else $error("compat query answered");
endmodule : sbsr_chk
bind sbsr_top sbsr_chk i_sbsr_chk (.*);

/* File: sbsr_host.sv */
// Host controller model issuing commands
`timescale 1ns/1ps
module sbsr_host (
	input wire logic clk_i, // Clock
	input wire logic ready_i, // Device ready
	input wire logic rsp_valid_i, // Answer strobe
	input wire logic [7:0] rsp_data_i, // Answer
	output sbsr_pkg::sbsr_cmd_t cmd_o, // Command
	output logic valid_o, // Command strobe
	output logic [7:0] data_o // Argument
);
	import sbsr_pkg::*;
	logic [7:0] rsp;
	logic got;
	initial begin
		valid_o = 1'b0;
		cmd_o = CMD_NONE;
		data_o = 8'h00;
	end
	// Hold request until taken, then look w falling edges for an answer
	// Outputs are read at falling edges, where they have settled
	task x(input sbsr_cmd_t c, input logic [7:0] d, input int w);
		@(negedge clk_i);
		valid_o = 1'b1;
		cmd_o = c;
		data_o = d;
		while (ready_i !== 1'b1) @(negedge clk_i);
		@(posedge clk_i);
		@(negedge clk_i);
		valid_o = 1'b0;
		data_o = ~d; // Idle argument never shows a stale value
		got = 1'b0;
		repeat (w) if (!got) begin
			if (rsp_valid_i === 1'b1) begin
				got = 1'b1;
				rsp = rsp_data_i;
			end else begin
				@(negedge clk_i);
			end
		end
		@(negedge clk_i);
	endtask : x
endmodule : sbsr_host

/* File: sbsr_top_bench.sv */
// Self-checking bench for the status byte block
`timescale 1ns/1ps
module sbsr_top_bench;
	import sbsr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic poc, lang, tsrc, dclr, pend, opsum, qsum, rpend, tfail, ovt, oc, otp, inh, valid, rdy, rsp_v, srq, trig, outen, epush;
	logic [7:0] nv, esr, ese, rsp_d, stb, dat;
	sbsr_cmd_t cmd;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int trigs = 0;
	int pushes = 0;
	always #5 clk = ~clk;
	sbsr_top #(.TEST_CYCLES(4)) i_sbsr_top (.CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(valid), .CMD_I(cmd),
		.CMD_DATA_I(dat), .CMD_READY_O(rdy), .RSP_DATA_O(rsp_d), .RSP_VALID_O(rsp_v), .POWER_ON_CLEAR_I(poc),
		.NV_SRE_I(nv), .LANG_STD_I(lang), .TRIG_SRC_BUS_I(tsrc), .DEVICE_CLEAR_I(dclr), .OPS_PENDING_I(pend),
		.OP_SUM_I(opsum), .QST_SUM_I(qsum), .RSP_PENDING_I(rpend), .ESR_EVENT_I(esr), .ESE_MASK_I(ese),
		.OVOLT_I(ovt), .OC_I(oc), .OTEMP_I(otp), .INHIBIT_I(inh), .TEST_FAIL_I(tfail), .SRQ_O(srq), .TRIGGER_O(trig),
		.OUTPUT_ON_O(outen), .ERR_PUSH_O(epush), .STB_O(stb));
	sbsr_host i_sbsr_host (.clk_i(clk), .ready_i(rdy), .rsp_valid_i(rsp_v), .rsp_data_i(rsp_d),
		.cmd_o(cmd), .valid_o(valid), .data_o(dat));
	////////////////////////////////////////////////////////////
	// Pulse counters and a ceiling well above the run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		trigs <= trigs + int'(trig === 1'b1);
		pushes <= pushes + int'(epush === 1'b1);
		if (cyc == 3000) begin
			fail_count++;
			end_of_test();
		end
	end
	task ck(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : ck
	// Query with an answer expected
	task q(input sbsr_cmd_t c, input logic [7:0] e);
		i_sbsr_host.x(c, 8'h00, 8);
		ck(i_sbsr_host.got ? i_sbsr_host.rsp : 8'hxx, e);
	endtask : q
	task reset_dut(input logic p);
		rst = 1'b1;
		poc = p;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
	endtask : reset_dut
	task end_of_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////
	// Main sequence; inputs change on falling edges only
	initial begin
		{poc, lang, tsrc, dclr, pend, opsum, qsum, rpend, tfail, ovt, oc, otp, inh} = '0;
		{esr, ese} = '0;
		nv = 8'h14;
		reset_dut(1'b0);
		ck({7'h0, outen}, 8'h00);
		q(CMD_READ_SRE, 8'h14);
		reset_dut(1'b1);
		q(CMD_READ_SRE, 8'h00);
		i_sbsr_host.x(CMD_SET_SRE, 8'h08, 3);
		q(CMD_READ_SRE, 8'h08);
		qsum = 1'b1;
		repeat (3) @(negedge clk);
		ck(stb, 8'h48);
		ck({7'h0, srq}, 8'h01);
		q(CMD_READ_STB, 8'h48);
		q(CMD_SERIAL_POLL, 8'h48);
		ck({srq, stb[6:0]}, 8'h48);
		q(CMD_SERIAL_POLL, 8'h08);
		i_sbsr_host.x(CMD_SET_SRE, 8'h00, 3);
		{opsum, rpend, ese, esr} = {2'b11, 8'h01, 8'h01};
		@(negedge clk) esr = 8'h00;
		repeat (2) @(negedge clk);
		ck(stb, 8'hb8);
		ck({7'h0, srq}, 8'h00);
		rpend = 1'b0;
		q(CMD_READ_ESR, 8'h01);
		@(negedge clk);
		ck(stb, 8'h88);
		tsrc = 1'b1;
		i_sbsr_host.x(CMD_BUS_TRIGGER, 8'h00, 3);
		tsrc = 1'b0;
		i_sbsr_host.x(CMD_BUS_TRIGGER, 8'h00, 3);
		ck(trigs[7:0], 8'h01);
		q(CMD_SELF_CHECK, 8'h00);
		tfail = 1'b1;
		q(CMD_SELF_CHECK, 8'h01);
		tfail = 1'b0;
		ck(8'(pushes != 0), 8'h01);
		pend = 1'b1;
		i_sbsr_host.x(CMD_HOLD, 8'h00, 3);
		ck({7'h0, rdy}, 8'h00);
		dclr = 1'b1;
		@(negedge clk) dclr = 1'b0;
		@(negedge clk);
		ck({7'h0, rdy}, 8'h01);
		pend = 1'b0;
		lang = 1'b1;
		for (int i = 0; i < 5; i++) begin
			{inh, otp, oc, ovt} = 4'(1 << i);
			q(CMD_ANY_TRIP, 8'(i < 4));
			q(CMD_CURR_TRIP, 8'(i == 1));
			q(CMD_VOLT_TRIP, 8'(i == 0));
		end
		i_sbsr_host.x(CMD_SET_OUTEN, 8'h01, 3);
		q(CMD_READ_OUTEN, 8'h01);
		lang = 1'b0;
		i_sbsr_host.x(CMD_SET_OUTEN, 8'h00, 3);
		ck({7'h0, outen}, 8'h01);
		i_sbsr_host.x(CMD_ANY_TRIP, 8'h00, 3);
		ck({7'h0, i_sbsr_host.got}, 8'h00);
		end_of_test();
	end
endmodule : sbsr_top_bench
